// >>> hw/sss_sequencer.sv
// Start-up and shut-down sequencer for the image sensor, with its constants package.
// Assumes clk is the reference clock input and that every input is synchronous to it.
`default_nettype none

package sss_pkg;
  // ----------------------------------------------------------------
  // Sequencing constants
  // ----------------------------------------------------------------
  // Reference clock cycles of internal initialisation after reset.
  localparam int INIT_REF_CYCLES = 150000;
  // Width of the initialisation counter; holds INIT_REF_CYCLES.
  localparam int INIT_CNT_W = 18;
  // Width of one pixel word on the parallel port.
  localparam int PIX_W = 12;
  // Plain defaults for the test frame geometry.
  localparam int ACT_COLS = 16;
  localparam int HBLANK_COLS = 4;
  localparam int ACT_ROWS = 8;
  localparam int VBLANK_ROWS = 2;
  // Stop selection values for the stop_at_row input.
  localparam logic STOP_AT_FRAME = 1'b0;
  localparam logic STOP_AT_ROW = 1'b1;

  // Operating states of the sensor.
  typedef enum logic [2:0] {
    SSS_HARD_RESET,
    SSS_INIT,
    SSS_STANDBY,
    SSS_STREAM,
    SSS_DRAIN
  } sss_state_t;
endpackage

// How it works
// - Pixel outputs tri-stated while reset held low.
// - Initialise 150000 clocks, then standby; host waits.
// - Streaming bit set moves standby into streaming.
// - Clearing streaming finishes row or frame first.
module sss_sequencer #(
  parameter int INIT_CYCLES = sss_pkg::INIT_REF_CYCLES,
  parameter int COLS = sss_pkg::ACT_COLS,
  parameter int HBLANK = sss_pkg::HBLANK_COLS,
  parameter int ROWS = sss_pkg::ACT_ROWS,
  parameter int VBLANK = sss_pkg::VBLANK_ROWS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hard_reset_n,
  input wire logic stream_on,
  input wire logic stop_at_row,
  output logic [sss_pkg::PIX_W-1:0] pix_data,
  output logic frame_valid,
  output logic line_valid,
  output logic pix_oe,
  output logic in_standby,
  output logic streaming
);
  import sss_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sss_state_t state_ff; // Current operating state.
  sss_state_t nxt_state; // State for the next cycle.
  logic [INIT_CNT_W-1:0] init_cnt_ff; // Cycles spent initialising.
  logic gen_run; // Frame timing runs while streaming or draining.
  logic gen_row_end; // Last cycle of a row, blanking included.
  logic gen_frame_end; // Last cycle of a frame, blanking included.
  logic gen_fv; // Frame valid from the timing generator.
  logic gen_lv; // Line valid from the timing generator.
  logic [PIX_W-1:0] gen_data; // Pixel word from the timing generator.
  logic drain_done; // The configured stop boundary has been reached.
  logic init_last; // Final initialisation cycle.
  logic [PIX_W-1:0] pix_data_ff; // Registered pixel word.
  logic frame_valid_ff; // Registered frame valid.
  logic line_valid_ff; // Registered line valid.
  logic pix_oe_ff; // Registered output enable of the parallel port.
  logic in_standby_ff; // Registered standby status.
  logic streaming_ff; // Registered streaming status.

  assign gen_run = (state_ff == SSS_STREAM) || (state_ff == SSS_DRAIN);
  assign init_last = (init_cnt_ff == INIT_CNT_W'(INIT_CYCLES - 1));
  assign drain_done = (stop_at_row == STOP_AT_ROW) ? gen_row_end : gen_frame_end;

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  sss_frame_gen #(
    .COLS(COLS),
    .HBLANK(HBLANK),
    .ROWS(ROWS),
    .VBLANK(VBLANK)
  ) u_frame_gen (
    .clk(clk),
    .reset(reset),
    .run(gen_run),
    .frame_valid(gen_fv),
    .line_valid(gen_lv),
    .pix_data(gen_data),
    .row_end(gen_row_end),
    .frame_end(gen_frame_end)
  );

  // ----------------------------------------------------------------
  // State sequencing
  // ----------------------------------------------------------------
  // Next state. The reset pin overrides every state, so a pulse on it
  // always restarts the full initialisation.
  always_comb begin
    nxt_state = state_ff;
    if (!hard_reset_n) begin
      nxt_state = SSS_HARD_RESET;
    end else begin
      unique case (state_ff)
        SSS_HARD_RESET: begin
          nxt_state = SSS_INIT;
        end
        SSS_INIT: begin
          // Standby only after the full initialisation count.
          if (init_last) begin
            nxt_state = SSS_STANDBY;
          end
        end
        SSS_STANDBY: begin
          if (stream_on) begin
            nxt_state = SSS_STREAM;
          end
        end
        SSS_STREAM: begin
          if (!stream_on) begin
            nxt_state = SSS_DRAIN;
          end
        end
        SSS_DRAIN: begin
          // Output carries on until the row or frame boundary; setting the
          // bit again here does not cancel the stop, which keeps it simple.
          if (drain_done) begin
            nxt_state = SSS_STANDBY;
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= SSS_HARD_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Initialisation counter; cleared outside the initialisation state.
  always_ff @(posedge clk) begin
    if (reset) begin
      init_cnt_ff <= '0;
    end else if (state_ff == SSS_INIT && hard_reset_n) begin
      init_cnt_ff <= init_cnt_ff + INIT_CNT_W'(1);
    end else begin
      init_cnt_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Parallel port and status outputs
  // ----------------------------------------------------------------
  // Output enable drops in the cycle after the pin goes low, and the
  // port stays quiet (driven low) until streaming starts.
  always_ff @(posedge clk) begin
    if (reset) begin
      pix_oe_ff <= 1'b0;
    end else begin
      pix_oe_ff <= hard_reset_n && (nxt_state != SSS_HARD_RESET);
    end
  end

  // Pixel words and strobes follow the generator one cycle later.
  always_ff @(posedge clk) begin
    if (reset || !hard_reset_n) begin
      pix_data_ff <= '0;
      frame_valid_ff <= 1'b0;
      line_valid_ff <= 1'b0;
    end else begin
      pix_data_ff <= gen_lv ? gen_data : '0;
      frame_valid_ff <= gen_fv;
      line_valid_ff <= gen_lv;
    end
  end

  // Status flags, aligned with the state register.
  always_ff @(posedge clk) begin
    if (reset) begin
      in_standby_ff <= 1'b0;
      streaming_ff <= 1'b0;
    end else begin
      in_standby_ff <= (nxt_state == SSS_STANDBY);
      streaming_ff <= (nxt_state == SSS_STREAM) || (nxt_state == SSS_DRAIN);
    end
  end

  assign pix_data = pix_data_ff;
  assign frame_valid = frame_valid_ff;
  assign line_valid = line_valid_ff;
  assign pix_oe = pix_oe_ff;
  assign in_standby = in_standby_ff;
  assign streaming = streaming_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_port_tristate: assert property (
    @(posedge clk) disable iff (reset) !hard_reset_n |=> !pix_oe && !frame_valid && !line_valid)
    else $error("Parallel port driven while reset pin low.");

  chk_init_early: assert property (
    @(posedge clk) disable iff (reset)
    (state_ff == SSS_INIT && !init_last && hard_reset_n) |=> state_ff == SSS_INIT)
    else $error("Left initialisation before the full count.");

  chk_init_exit: assert property (
    @(posedge clk) disable iff (reset)
    (state_ff == SSS_INIT && init_last && hard_reset_n) |=> in_standby && state_ff == SSS_STANDBY)
    else $error("Standby not entered after initialisation.");

  chk_stream_start: assert property (
    @(posedge clk) disable iff (reset)
    (state_ff == SSS_STANDBY && stream_on && hard_reset_n) |=> streaming ##1 frame_valid)
    else $error("Streaming did not start with a frame.");

  chk_drain_hold: assert property (
    @(posedge clk) disable iff (reset)
    (state_ff == SSS_DRAIN && !drain_done && hard_reset_n) |=> state_ff == SSS_DRAIN && streaming)
    else $error("Stopped before the row or frame boundary.");

  chk_drain_end: assert property (
    @(posedge clk) disable iff (reset)
    (state_ff == SSS_DRAIN && drain_done && hard_reset_n) |=> in_standby ##1 !frame_valid)
    else $error("Standby not reached at the boundary.");
endmodule

`default_nettype wire

// >>> hw/sss_frame_gen.sv
// Row and frame timing generator with a counting test pattern.
// Assumes the sequencer package is compiled first; counters hold at zero while run is low.
`default_nettype none

module sss_frame_gen #(
  parameter int COLS = sss_pkg::ACT_COLS,
  parameter int HBLANK = sss_pkg::HBLANK_COLS,
  parameter int ROWS = sss_pkg::ACT_ROWS,
  parameter int VBLANK = sss_pkg::VBLANK_ROWS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic frame_valid,
  output logic line_valid,
  output logic [sss_pkg::PIX_W-1:0] pix_data,
  output logic row_end,
  output logic frame_end
);
  import sss_pkg::*;

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  localparam int LINE_LEN = COLS + HBLANK; // Cycles per row.
  localparam int FRAME_LEN = ROWS + VBLANK; // Rows per frame.
  localparam int COL_W = $clog2(LINE_LEN + 1);
  localparam int ROW_W = $clog2(FRAME_LEN + 1);

  logic [COL_W-1:0] col_ff; // Position within the row.
  logic [ROW_W-1:0] row_ff; // Position within the frame.

  assign row_end = run && (col_ff == COL_W'(LINE_LEN - 1));
  assign frame_end = row_end && (row_ff == ROW_W'(FRAME_LEN - 1));

  // Column counter; restarts each row so a stop always lands on a boundary.
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      col_ff <= '0;
    end else if (row_end) begin
      col_ff <= '0;
    end else begin
      col_ff <= col_ff + COL_W'(1);
    end
  end

  // Row counter, advanced on each row end.
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      row_ff <= '0;
    end else if (frame_end) begin
      row_ff <= '0;
    end else if (row_end) begin
      row_ff <= row_ff + ROW_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Strobes and pattern
  // ----------------------------------------------------------------
  assign frame_valid = run && (row_ff < ROW_W'(ROWS));
  assign line_valid = frame_valid && (col_ff < COL_W'(COLS));
  assign pix_data = PIX_W'({row_ff, col_ff});
endmodule

`default_nettype wire

// >>> hw/sss_sequencer_end.sv
// Holds no logic: the sequencer and its frame timing generator live in their own files.

// >>> verification/sss_host_model.sv
// Host controller model: drives the sensor reset pin and the streaming controls.
// Assumes clk is the running reference clock and calls come at its falling edge.
`default_nettype none
module sss_host_model #(
  parameter int LOCK_CYCLES = 8
) (
  input wire logic clk,
  input wire logic in_standby,
  output logic hard_reset_n,
  output logic stream_on,
  output logic stop_at_row
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rails and clock are taken as settled at time zero, so reset starts low.
  initial begin
    hard_reset_n = 1'b0;
    stream_on = 1'b0;
    stop_at_row = 1'b0;
  end
  // Hold the reset pin low for a span of clock cycles, then release it.
  task automatic pulse_reset(input int cycles);
    hard_reset_n <= 1'b0;
    repeat (cycles) @(negedge clk);
    hard_reset_n <= 1'b1;
  endtask
  // Settings are written in standby; the lock wait is shortened to save run time.
  task automatic start_stream();
    while (in_standby !== 1'b1) @(negedge clk);
    repeat (LOCK_CYCLES) @(negedge clk);
    stream_on <= 1'b1;
  endtask
  // Clear the streaming bit with the chosen stop boundary.
  task automatic stop_stream(input logic row_mode);
    stop_at_row <= row_mode;
    stream_on <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_sss_sequencer.sv
// Self-checking bench for the sensor start-up and shut-down sequencer.
// Assumes the design package and the host model are compiled first.
`default_nettype none
module tb_sss_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import sss_pkg::*;
  // Short initialisation keeps the run small; expectations derive from it.
  localparam int INIT = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hard_reset_n, stream_on, stop_at_row;
  logic [PIX_W-1:0] pix_data;
  logic frame_valid, line_valid, pix_oe, in_standby, streaming;
  int failures = 0;
  int total_checks = 0;
  always #4 clk = ~clk;
  sss_host_model host_u (.clk(clk), .in_standby(in_standby), .hard_reset_n(hard_reset_n),
    .stream_on(stream_on), .stop_at_row(stop_at_row));
  sss_sequencer #(.INIT_CYCLES(INIT)) dut_u (.clk(clk), .reset(reset), .hard_reset_n(hard_reset_n),
    .stream_on(stream_on), .stop_at_row(stop_at_row), .pix_data(pix_data), .frame_valid(frame_valid),
    .line_valid(line_valid), .pix_oe(pix_oe), .in_standby(in_standby), .streaming(streaming));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sample just after the rising edge so registered outputs have settled.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Count a comparison and report it at once if it does not hold.
  task automatic check(input logic ok, input string msg);
    total_checks++;
    // An unknown result counts as a mismatch, never as a pass.
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  // Print the counts and the verdict, then stop.
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Pulse the reset pin, even in mid-stream, and time the climb into standby.
  task automatic test_reset();
    int n;
    @(negedge clk);
    fork
      host_u.pulse_reset(6);
      begin
        tick();
        tick();
        check(pix_oe === 1'b0 && line_valid === 1'b0 && streaming === 1'b0, "port not released");
      end
    join
    n = 0;
    do begin
      tick();
      n++;
      if (n == 2) check(pix_oe === 1'b1, "port not enabled after reset");
    end while (in_standby !== 1'b1 && n < 100);
    // The first counted edge samples the pin high; standby shows INIT edges later.
    check(n == INIT + 1 && streaming === 1'b0, "init length wrong");
    $display("test reset done");
  endtask
  // Request streaming and follow the first row word by word.
  task automatic test_start();
    int n;
    host_u.start_stream();
    n = 0;
    do begin
      tick();
      n++;
    end while (streaming !== 1'b1 && n < 4);
    check(n <= 2 && in_standby === 1'b0, "streaming late");
    tick();
    check(frame_valid === 1'b1 && line_valid === 1'b1 && pix_data === '0, "first word");
    for (int i = 1; i < ACT_COLS; i++) begin
      tick();
      check(line_valid === 1'b1 && pix_data === PIX_W'(i), "row word");
    end
    repeat (HBLANK_COLS) begin
      tick();
      check(line_valid === 1'b0, "row blanking");
    end
    tick();
    check(line_valid === 1'b1, "second row missing");
    repeat (3) tick();
    $display("test start done");
  endtask
  // Stop mid-row; drain must reach the row or frame boundary before standby.
  task automatic test_stop(input logic row_mode, input int rows_left);
    int n;
    int rises;
    logic lv_q;
    @(negedge clk);
    host_u.stop_stream(row_mode);
    n = 0;
    rises = 0;
    lv_q = line_valid;
    do begin
      tick();
      n++;
      if (line_valid === 1'b1 && lv_q === 1'b0) rises++;
      lv_q = line_valid;
    end while (in_standby !== 1'b1 && n < 400);
    check(rises == rows_left && n > HBLANK_COLS && streaming === 1'b0, "stop boundary");
    tick();
    check(frame_valid === 1'b0 && line_valid === 1'b0, "frame not closed");
    $display("test stop done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    test_reset();
    test_start();
    test_stop(STOP_AT_ROW, 0);
    test_start();
    test_stop(STOP_AT_FRAME, ACT_ROWS - 2);
    test_start();
    test_reset();
    finish_test();
  end
  // The scenarios need well under a thousand cycles; this bound cuts a hang.
  initial begin
    #(8 * 5000);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
